// ---- common/gpm_pkg.sv ----
// constants, layouts and types of the global performance monitor control block
//
// Notes on behaviour
// [R1] global control at model-specific address 0x0700, global status at 0x0701, documented 32 bits
// [R2] writing 1 to write-only freeze-all bit 63 stops every counter
// [R3] writing 1 to write-only unfreeze-all bit 61 restarts all counting
// [R4] wake bit 62: 0 interrupts awake cores only, 1 wakes sleepers and interrupts all
// [R5] bits 27:0 of control are a read-write mask of cores receiving the interrupt
// [R6] with wake bit set, selected sleeping cores get a wake before the interrupt
// [R7] each counter has a software option whether its overflow reaches the global block
// [R8] a reported overflow raises the global freeze sent to all units
// [R9] each unit stops all its counters while the global freeze is seen
// [R10] while freezing, the interrupt goes to the selected cores if so configured
// [R11] software may preset a counter so it overflows after a chosen event count
// [R12] global status holds one sticky overflow bit per reporting source
// [R13] writing 1 to a status bit clears it, writing 0 leaves it
// [R14] status 63,62 mesh-memory units; 60 multichip stack; 59..56 periph and common stacks
// [R15] status 47,46 link-mesh units; 43..41 coherent link agents; 40,39 memory controllers
// [R16] status 30:3 one bit per caching home agent, agent 0 at bit 3
// [R17] status bit 2 power unit, bit 1 utility counters, bit 0 utility fixed counter
// [R18] software programs a counter's control and periodically reads its paired counter
// [R19] a unit's overflow status bit sets on counter overflow, clears on write of 1
// [R20] all fields reset to zero, reserved bits read zero, reserved writes ignored
package gpm_pkg;
   // -------------------------------------------------------------
   // register access port
   // -------------------------------------------------------------
   localparam int                    MSR_ADDR_W          = 16;
   localparam int                    MSR_DATA_W          = 64;
   localparam int                    MSR_DOC_SIZE        = 32;
   localparam logic [MSR_ADDR_W-1:0] GLOBAL_CTL_ADDR     = 16'h0700;
   localparam logic [MSR_ADDR_W-1:0] GLOBAL_STATUS_ADDR  = 16'h0701;
   localparam logic [MSR_ADDR_W-1:0] REPORT_EN_BASE      = 16'h0710;
   localparam logic [MSR_ADDR_W-1:0] UNIT_STATUS_BASE    = 16'h0718;
   localparam int                    GROUP_COUNT         = 4;
   localparam int                    GRP_IDX_W           = 2;
   localparam int                    SRC_COUNT           = 64;
   localparam int                    SRC_PER_GROUP       = 16;
   localparam int                    CTRS_PER_UNIT       = 4;

   // -------------------------------------------------------------
   // global control fields
   // -------------------------------------------------------------
   localparam int                    FRZ_ALL_BIT         = 63;
   localparam int                    WAKE_BIT            = 62;
   localparam int                    UNFRZ_ALL_BIT       = 61;
   localparam int                    CORE_SEL_LSB        = 0;
   localparam int                    CORE_SEL_W          = 28;
   localparam logic [63:0]           CTL_RESET           = 64'h0;
   localparam logic [63:0]           CTL_WRITE_MASK      = (64'h1 << WAKE_BIT) |
                                                           (((64'h1 << CORE_SEL_W) - 64'h1) << CORE_SEL_LSB);

   // -------------------------------------------------------------
   // global status fields
   // -------------------------------------------------------------
   localparam int                    MESH_MEMORY1_BIT    = 63;
   localparam int                    MESH_MEMORY0_BIT    = 62;
   localparam int                    MULTICHIP_BIT       = 60;
   localparam int                    PERIPH_COMMON_LSB   = 56;
   localparam int                    PERIPH_COMMON_W     = 4;
   localparam int                    LINK_MESH1_BIT      = 47;
   localparam int                    LINK_MESH0_BIT      = 46;
   localparam int                    LINK_AGENT_LSB      = 41;
   localparam int                    LINK_AGENT_W        = 3;
   localparam int                    MEMCTL_LSB          = 39;
   localparam int                    MEMCTL_W            = 2;
   localparam int                    HOME_AGENT_LSB      = 3;
   localparam int                    HOME_AGENT_W        = 28;
   localparam int                    POWER_UNIT_BIT      = 2;
   localparam int                    UTILITY_BOX_BIT     = 1;
   localparam int                    UTILITY_FIXED_BIT   = 0;
   localparam logic [63:0]           STATUS_RESET        = 64'h0;
   localparam logic [63:0]           STATUS_VALID_MASK   =
      (64'h1 << MESH_MEMORY1_BIT) | (64'h1 << MESH_MEMORY0_BIT) | (64'h1 << MULTICHIP_BIT) |
      (((64'h1 << PERIPH_COMMON_W) - 64'h1) << PERIPH_COMMON_LSB) |
      (64'h1 << LINK_MESH1_BIT) | (64'h1 << LINK_MESH0_BIT) |
      (((64'h1 << LINK_AGENT_W) - 64'h1) << LINK_AGENT_LSB) |
      (((64'h1 << MEMCTL_W) - 64'h1) << MEMCTL_LSB) |
      (((64'h1 << HOME_AGENT_W) - 64'h1) << HOME_AGENT_LSB) |
      (64'h1 << POWER_UNIT_BIT) | (64'h1 << UTILITY_BOX_BIT) | (64'h1 << UTILITY_FIXED_BIT);

   // -------------------------------------------------------------
   // wake timing
   // -------------------------------------------------------------
   localparam int                    CLK_PERIOD_NS       = 100;
   localparam int                    WAKE_WAIT_NS        = 2000;
   localparam int                    TMR_W               = 8;
   localparam int                    WAKE_WAIT_RAW       = WAKE_WAIT_NS / CLK_PERIOD_NS;
   localparam logic [TMR_W-1:0]      WAKE_WAIT_CYCLES    = TMR_W'((WAKE_WAIT_RAW < 1) ? 1 : WAKE_WAIT_RAW);

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [MSR_ADDR_W-1:0] addr;
      logic [MSR_DATA_W-1:0] wdata;
   } gpm_msr_req_t;

   typedef struct packed {
      logic                  ack;
      logic [MSR_DATA_W-1:0] rdata;
   } gpm_msr_rsp_t;

   typedef enum logic [1:0] {
      GPM_IDLE = 2'b00,
      GPM_WAKE = 2'b01
   } gpm_state_t;
endpackage : gpm_pkg

// ---- hdl/gpm_source_slice.sv ----
// one reporting source: per-counter overflow status and report gating
`timescale 1ns/10ps
module gpm_source_slice
   import gpm_pkg::*;
#(
   parameter int CTRS = CTRS_PER_UNIT
) (
   input  wire logic            clock_in,
   input  wire logic            reset_n_in,
   input  wire logic            clk_en_in,
   input  wire logic [CTRS-1:0] ctr_overflow_in,
   input  wire logic [CTRS-1:0] report_en_in,
   input  wire logic [CTRS-1:0] clear_in,
   output logic      [CTRS-1:0] unit_status_out,
   output logic                 report_out
);
   // -------------------------------------------------------------
   // status and report
   // -------------------------------------------------------------
   logic [CTRS-1:0] status_ff;
   logic            report_ff;
   wire  [CTRS-1:0] nxt_status = (status_ff & ~clear_in) | ctr_overflow_in; // [R19]
   wire             nxt_report = |(ctr_overflow_in & report_en_in);         // [R7]

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         status_ff <= '0;
         report_ff <= 1'b0;
      end else if (clk_en_in) begin
         status_ff <= nxt_status;
         report_ff <= nxt_report;
      end
   end

   assign unit_status_out = status_ff;
   assign report_out      = report_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   property p_unit_set_wins;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && (ctr_overflow_in != '0)) |=> ((status_ff & $past(ctr_overflow_in)) == $past(ctr_overflow_in));
   endproperty
   a_unit_set_wins: assert property (p_unit_set_wins) else $error("unit overflow status lost"); // [R19]
endmodule : gpm_source_slice

// ---- hdl/gpm_global_ctl.sv ----
// global control and overflow status of the performance monitor hierarchy
`timescale 1ns/10ps
module gpm_global_ctl
   import gpm_pkg::*;
#(
   parameter int NUM_CORES = CORE_SEL_W
) (
   input  wire logic                          clock_in,
   input  wire logic                          reset_n_in,
   input  wire logic                          clk_en_in,
   input  wire gpm_msr_req_t                  msr_req_in,
   input  wire logic [SRC_COUNT*CTRS_PER_UNIT-1:0] ctr_overflow_in,
   input  wire logic [NUM_CORES-1:0]          core_awake_in,
   output gpm_msr_rsp_t                       msr_rsp_out,
   output logic                               global_freeze_out,
   output logic      [NUM_CORES-1:0]          core_wake_out,
   output logic      [NUM_CORES-1:0]          core_pmi_out
);
   localparam int VEC_W = SRC_COUNT * CTRS_PER_UNIT;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [63:0]          ctl_ff;
   logic [63:0]          status_ff;
   logic [VEC_W-1:0]     rpt_en_ff;
   logic                 freeze_ff;
   logic                 pending_ff;
   gpm_state_t           state_ff;
   logic [NUM_CORES-1:0] target_ff;
   logic [NUM_CORES-1:0] wake_ff;
   logic [NUM_CORES-1:0] pmi_ff;
   logic [TMR_W-1:0]     timer_ff;
   gpm_msr_rsp_t         rsp_ff;

   // -------------------------------------------------------------
   // register decode
   // -------------------------------------------------------------
   wire                  req_wr    = msr_req_in.valid && msr_req_in.write;
   wire                  req_rd    = msr_req_in.valid && !msr_req_in.write;
   wire [63:0]           wr_data   = msr_req_in.wdata;
   wire [MSR_ADDR_W-1:0] rpt_off   = msr_req_in.addr - REPORT_EN_BASE;
   wire [MSR_ADDR_W-1:0] ust_off   = msr_req_in.addr - UNIT_STATUS_BASE;
   wire                  hit_ctl   = msr_req_in.addr == GLOBAL_CTL_ADDR;    // [R1]
   wire                  hit_stat  = msr_req_in.addr == GLOBAL_STATUS_ADDR; // [R1]
   wire                  hit_rpt   = rpt_off < MSR_ADDR_W'(GROUP_COUNT);
   wire                  hit_ust   = ust_off < MSR_ADDR_W'(GROUP_COUNT);
   wire [GRP_IDX_W-1:0]  rpt_grp   = rpt_off[GRP_IDX_W-1:0];
   wire [GRP_IDX_W-1:0]  ust_grp   = ust_off[GRP_IDX_W-1:0];
   wire                  wr_ctl    = req_wr && hit_ctl;
   wire                  wr_stat   = req_wr && hit_stat;
   wire                  wr_rpt    = req_wr && hit_rpt;
   wire                  wr_ust    = req_wr && hit_ust;
   wire                  rd_stat   = req_rd && hit_stat;
   wire                  frz_cmd   = wr_ctl && wr_data[FRZ_ALL_BIT];   // [R2]
   wire                  unfrz_cmd = wr_ctl && wr_data[UNFRZ_ALL_BIT]; // [R3]

   // -------------------------------------------------------------
   // reporting sources
   // -------------------------------------------------------------
   logic [SRC_COUNT-1:0] report_vec;
   logic [VEC_W-1:0]     unit_status;
   logic [VEC_W-1:0]     ust_clear;
   logic [VEC_W-1:0]     rpt_valid;
   logic [VEC_W-1:0]     nxt_rpt_en;

   // reserved positions get no slice, so their bits stay zero for good
   for (genvar i = 0; i < SRC_COUNT; i++) begin : g_src
      if (STATUS_VALID_MASK[i]) begin : g_on
         assign rpt_valid[i*CTRS_PER_UNIT +: CTRS_PER_UNIT] = '1;
         assign ust_clear[i*CTRS_PER_UNIT +: CTRS_PER_UNIT] =
            (wr_ust && ust_grp == GRP_IDX_W'(i / SRC_PER_GROUP))
            ? wr_data[(i % SRC_PER_GROUP)*CTRS_PER_UNIT +: CTRS_PER_UNIT] : '0;
         gpm_source_slice #(
            .CTRS            (CTRS_PER_UNIT)
         ) u_slice (
            .clock_in        (clock_in),
            .reset_n_in      (reset_n_in),
            .clk_en_in       (clk_en_in),
            .ctr_overflow_in (ctr_overflow_in[i*CTRS_PER_UNIT +: CTRS_PER_UNIT]),
            .report_en_in    (rpt_en_ff[i*CTRS_PER_UNIT +: CTRS_PER_UNIT]),
            .clear_in        (ust_clear[i*CTRS_PER_UNIT +: CTRS_PER_UNIT]),
            .unit_status_out (unit_status[i*CTRS_PER_UNIT +: CTRS_PER_UNIT]),
            .report_out      (report_vec[i])
         );
      end else begin : g_off
         assign rpt_valid[i*CTRS_PER_UNIT +: CTRS_PER_UNIT]   = '0;
         assign ust_clear[i*CTRS_PER_UNIT +: CTRS_PER_UNIT]   = '0;
         assign unit_status[i*CTRS_PER_UNIT +: CTRS_PER_UNIT] = '0;
         assign report_vec[i]                                 = 1'b0;
      end
   end

   for (genvar g = 0; g < GROUP_COUNT; g++) begin : g_grp
      assign nxt_rpt_en[g*64 +: 64] = (wr_rpt && rpt_grp == GRP_IDX_W'(g))
                                      ? (wr_data & rpt_valid[g*64 +: 64]) : rpt_en_ff[g*64 +: 64]; // [R7] [R20]
   end

   // -------------------------------------------------------------
   // control, status and freeze
   // -------------------------------------------------------------
   wire        ovf_event  = |report_vec;
   wire [63:0] stat_clr   = wr_stat ? (wr_data & STATUS_VALID_MASK) : 64'h0;          // [R13]
   // a clear landing with a new overflow keeps the bit: set wins
   wire [63:0] nxt_status = (status_ff & ~stat_clr) | report_vec;                     // [R12] [R14] [R15] [R16] [R17]
   wire [63:0] nxt_ctl    = wr_ctl ? (wr_data & CTL_WRITE_MASK) : ctl_ff;             // [R5] [R20]
   // freeze beats unfreeze when both arrive together, stopping is the safe side
   wire        nxt_freeze = frz_cmd || ovf_event || (freeze_ff && !unfrz_cmd);        // [R2] [R3] [R8]

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctl_ff    <= CTL_RESET;
         status_ff <= STATUS_RESET;
         rpt_en_ff <= '0;
         freeze_ff <= 1'b0;
      end else if (clk_en_in) begin
         ctl_ff    <= nxt_ctl;
         status_ff <= nxt_status;
         rpt_en_ff <= nxt_rpt_en;
         freeze_ff <= nxt_freeze;
      end
   end

   // -------------------------------------------------------------
   // interrupt delivery
   // -------------------------------------------------------------
   wire [NUM_CORES-1:0] core_sel    = ctl_ff[CORE_SEL_LSB +: NUM_CORES];              // [R5]
   wire                 wake_mode   = ctl_ff[WAKE_BIT];
   wire                 want_irq    = (pending_ff || ovf_event) && (core_sel != '0);  // [R10]
   wire                 in_idle     = state_ff == GPM_IDLE;
   wire                 in_wake     = state_ff == GPM_WAKE;
   wire [NUM_CORES-1:0] sleepers    = core_sel & ~core_awake_in;
   wire                 go_wake     = in_idle && want_irq && wake_mode && (sleepers != '0); // [R6]
   wire                 send_now    = in_idle && want_irq && !go_wake;
   wire                 wake_done   = in_wake && (((target_ff & ~core_awake_in) == '0) || timer_ff == '0);
   // an event arriving while the wake is in flight is kept for the next round
   wire                 nxt_pending = (in_idle && (pending_ff || ovf_event)) ? 1'b0 : (pending_ff || ovf_event);
   wire [NUM_CORES-1:0] send_set    = wake_mode ? core_sel : (core_sel & core_awake_in); // [R4]
   wire [NUM_CORES-1:0] nxt_pmi     = send_now ? send_set : (wake_done ? target_ff : '0); // [R4] [R10]
   wire [NUM_CORES-1:0] nxt_wake    = go_wake ? sleepers : (wake_done ? '0 : wake_ff);   // [R6]
   wire [NUM_CORES-1:0] nxt_target  = go_wake ? core_sel : target_ff;
   wire [TMR_W-1:0]     nxt_timer   = go_wake ? WAKE_WAIT_CYCLES : (in_wake ? timer_ff - TMR_W'(1) : timer_ff);
   gpm_state_t          nxt_state;

   always_comb begin
      case (state_ff)
         GPM_IDLE: begin
            nxt_state = go_wake ? GPM_WAKE : GPM_IDLE;
         end
         GPM_WAKE: begin
            nxt_state = wake_done ? GPM_IDLE : GPM_WAKE;
         end
         default: begin
            nxt_state = GPM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_ff   <= GPM_IDLE;
         pending_ff <= 1'b0;
         target_ff  <= '0;
         wake_ff    <= '0;
         pmi_ff     <= '0;
         timer_ff   <= '0;
      end else if (clk_en_in) begin
         state_ff   <= nxt_state;
         pending_ff <= nxt_pending;
         target_ff  <= nxt_target;
         wake_ff    <= nxt_wake;
         pmi_ff     <= nxt_pmi;
         timer_ff   <= nxt_timer;
      end
   end

   // -------------------------------------------------------------
   // read answer
   // -------------------------------------------------------------
   // write-only bits have no storage, so they read back as zero
   wire [63:0] rd_data = hit_ctl  ? ctl_ff :
                         hit_stat ? status_ff :
                         hit_rpt  ? rpt_en_ff[rpt_grp*64 +: 64] :
                         hit_ust  ? unit_status[ust_grp*64 +: 64] : 64'h0;             // [R20]
   gpm_msr_rsp_t nxt_rsp;
   assign nxt_rsp.ack   = msr_req_in.valid;
   assign nxt_rsp.rdata = req_rd ? rd_data : 64'h0;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rsp_ff <= '0;
      end else if (clk_en_in) begin
         rsp_ff <= nxt_rsp;
      end
   end

   assign msr_rsp_out       = rsp_ff;
   assign global_freeze_out = freeze_ff; // [R9]
   assign core_wake_out     = wake_ff;
   assign core_pmi_out      = pmi_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   property p_ctl_write;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && wr_ctl) |=> (ctl_ff == ($past(wr_data) & CTL_WRITE_MASK));
   endproperty
   a_ctl_write: assert property (p_ctl_write) else $error("control write not stored"); // [R5]

   property p_freeze_cmd;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && frz_cmd) |=> global_freeze_out;
   endproperty
   a_freeze_cmd: assert property (p_freeze_cmd) else $error("freeze-all did not freeze"); // [R2]

   property p_unfreeze_cmd;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && unfrz_cmd && !frz_cmd && !ovf_event) |=> !global_freeze_out;
   endproperty
   a_unfreeze_cmd: assert property (p_unfreeze_cmd) else $error("unfreeze-all did not release"); // [R3]

   property p_ovf_freeze;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && ovf_event) |=> global_freeze_out;
   endproperty
   a_ovf_freeze: assert property (p_ovf_freeze) else $error("overflow did not freeze"); // [R8]

   property p_status_sticky;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && ovf_event) |=> ((status_ff & $past(report_vec)) == $past(report_vec));
   endproperty
   a_status_sticky: assert property (p_status_sticky) else $error("overflow status not set"); // [R12]

   property p_status_w1c;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && wr_stat && !ovf_event) |=> ((status_ff & $past(wr_data)) == 64'h0);
   endproperty
   a_status_w1c: assert property (p_status_w1c) else $error("status bit not cleared"); // [R13]

   property p_awake_only;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && send_now && !wake_mode) |=> ((core_pmi_out & ~$past(core_awake_in)) == '0);
   endproperty
   a_awake_only: assert property (p_awake_only) else $error("interrupt sent to sleeping core"); // [R4]

   property p_wake_first;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && go_wake) |=> (core_wake_out != '0) && (core_pmi_out == '0);
   endproperty
   a_wake_first: assert property (p_wake_first) else $error("wake not sent before interrupt"); // [R6]

   property p_reserved_zero;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && rd_stat) |=> msr_rsp_out.ack && ((msr_rsp_out.rdata & ~STATUS_VALID_MASK) == 64'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bits not zero"); // [R20]

   property p_mask_gate;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && send_now) |=> ((core_pmi_out & ~$past(core_sel)) == '0);
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("interrupt outside core mask"); // [R5]

   property p_wake_all;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && send_now && wake_mode) |=> (core_pmi_out == $past(core_sel));
   endproperty
   a_wake_all: assert property (p_wake_all) else $error("wake mode missed a masked core"); // [R4]

   property p_no_mask;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && in_idle && (core_sel == '0)) |=> (core_pmi_out == '0);
   endproperty
   a_no_mask: assert property (p_no_mask) else $error("interrupt with empty mask"); // [R10]

   property p_wake_hold;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && in_wake && !wake_done) |=> (core_pmi_out == '0);
   endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("interrupt during wake phase"); // [R6]

   property p_wake_then_irq;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && wake_done) |=> (core_pmi_out == $past(target_ff)) && (core_wake_out == '0);
   endproperty
   a_wake_then_irq: assert property (p_wake_then_irq) else $error("no interrupt after wake"); // [R6]

   property p_req_ack;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && msr_req_in.valid) |=> msr_rsp_out.ack;
   endproperty
   a_req_ack: assert property (p_req_ack) else $error("register access not acknowledged"); // [R1]

   property p_ctl_wo_zero;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && req_rd && hit_ctl) |=> ((msr_rsp_out.rdata & ~CTL_WRITE_MASK) == 64'h0);
   endproperty
   a_ctl_wo_zero: assert property (p_ctl_wo_zero) else $error("control reserved bits not zero"); // [R20]

   property p_freeze_hold;
      @(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && global_freeze_out && !unfrz_cmd) |=> global_freeze_out;
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("freeze dropped without unfreeze"); // [R8]
endmodule : gpm_global_ctl

// ---- tb/gpm_core_model.sv ----
// behavioural model of the processor cores facing the wake output and driving the awake input
`timescale 1ns/10ps
module gpm_core_model
   import gpm_pkg::*;
#(
   parameter int NUM_CORES = CORE_SEL_W
) (
   input  wire logic                 clock_in,
   input  wire logic                 reset_n_in,
   input  wire logic [NUM_CORES-1:0] sleep_in,
   input  wire logic [NUM_CORES-1:0] wake_in,
   output logic      [NUM_CORES-1:0] awake_out
);
   logic [NUM_CORES-1:0] asleep_ff;
   logic [NUM_CORES-1:0] wake_d_ff;
   // a woken core needs two edges, so the wake phase is really waited on
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         asleep_ff <= sleep_in;
         wake_d_ff <= '0;
      end else begin
         wake_d_ff <= wake_in;
         asleep_ff <= asleep_ff & ~wake_d_ff;
      end
   end
   assign awake_out = ~asleep_ff;
endmodule : gpm_core_model

// ---- tb/gpm_global_ctl_tb.sv ----
// self-checking testbench of the global performance monitor control block
`timescale 1ns/10ps
module gpm_global_ctl_tb
   import gpm_pkg::*;
;
   logic           clock_in, reset_n_in, freeze, en;
   gpm_msr_req_t   req;
   gpm_msr_rsp_t   rsp;
   logic [255:0]   ovf;
   logic [27:0]    awake, sleep_m, wake, pmi, p, w;
   logic [63:0]    rd;
   int             bad_count, check_count;

   gpm_global_ctl i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .clk_en_in(en),
      .msr_req_in(req), .ctr_overflow_in(ovf), .core_awake_in(awake), .msr_rsp_out(rsp),
      .global_freeze_out(freeze), .core_wake_out(wake), .core_pmi_out(pmi));
   gpm_core_model i_cores (.clock_in(clock_in), .reset_n_in(reset_n_in), .sleep_in(sleep_m),
      .wake_in(wake), .awake_out(awake));

   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic msr(input logic wr, input logic [15:0] a, input logic [63:0] d);
      @(negedge clock_in);
      req = '{1'b1, wr, a, d};
      @(negedge clock_in);
      req.valid = 1'b0;
      chk({63'h0, rsp.ack}, 64'h1);
      rd = rsp.rdata;
   endtask : msr

   // pulse overflows, then wait bounded for the interrupt, noting any wake seen first
   task automatic pulse(input logic [255:0] v);
      @(negedge clock_in);
      ovf = v;
      @(negedge clock_in);
      ovf = '0;
      p = '0;
      w = '0;
      for (int i = 0; i < 40 && p === 28'h0; i++) begin
         @(negedge clock_in);
         if (wake !== 28'h0) w = wake;
         p = pmi;
      end
      @(negedge clock_in);
      chk({36'h0, pmi}, 64'h0);
   endtask : pulse

   task automatic t_reset();
      msr(1'b0, 16'h0700, 64'h0);
      chk(rd, 64'h0);
      msr(1'b0, 16'h0701, 64'h0);
      chk(rd, 64'h0);
      msr(1'b1, 16'h0123, 64'hFF);
      msr(1'b0, 16'h0123, 64'h0);
      chk(rd, 64'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_ctl();
      msr(1'b1, 16'h0700, '1);
      chk({63'h0, freeze}, 64'h1);
      msr(1'b0, 16'h0700, 64'h0);
      chk(rd, CTL_WRITE_MASK);
      msr(1'b1, 16'h0700, 64'h1 << UNFRZ_ALL_BIT);
      chk({63'h0, freeze}, 64'h0);
      $display("test control done");
   endtask : t_ctl

   task automatic t_ovf();
      msr(1'b1, 16'h0710, 64'h1);
      msr(1'b0, 16'h0710, 64'h0);
      chk(rd, 64'h1);
      msr(1'b1, 16'h0700, 64'hF0F);
      pulse(256'h13);
      chk({36'h0, p}, 64'hF0E);
      chk({63'h0, freeze}, 64'h1);
      msr(1'b0, 16'h0701, 64'h0);
      chk(rd, 64'h1);
      msr(1'b0, 16'h0718, 64'h0);
      chk(rd, 64'h13);
      msr(1'b1, 16'h0718, 64'h13);
      msr(1'b0, 16'h0718, 64'h0);
      chk(rd, 64'h0);
      msr(1'b1, 16'h0701, 64'h0);
      msr(1'b0, 16'h0701, 64'h0);
      chk(rd, 64'h1);
      msr(1'b1, 16'h0701, 64'h1);
      msr(1'b0, 16'h0701, 64'h0);
      chk(rd, 64'h0);
      msr(1'b1, 16'h0700, 64'h1 << UNFRZ_ALL_BIT);
      $display("test overflow done");
   endtask : t_ovf

   task automatic t_wake();
      msr(1'b1, 16'h0700, (64'h1 << WAKE_BIT) | 64'hF0F);
      pulse(256'h1);
      chk({36'h0, w}, 64'h1);
      chk({36'h0, p}, 64'hF0F);
      $display("test wake done");
   endtask : t_wake

   // a request met with the enable low must leave no trace
   task automatic t_en();
      @(negedge clock_in);
      en = 1'b0;
      req = '{1'b1, 1'b1, GLOBAL_CTL_ADDR, 64'h0};
      @(negedge clock_in);
      req = '0;
      en = 1'b1;
      chk({63'h0, rsp.ack}, 64'h0);
      msr(1'b0, 16'h0700, 64'h0);
      chk(rd, (64'h1 << WAKE_BIT) | 64'hF0F);
      $display("test clock enable done");
   endtask : t_en

   task automatic t_map();
      for (int g = 0; g < 4; g++) msr(1'b1, REPORT_EN_BASE + 16'(g), '1);
      msr(1'b1, 16'h0701, '1);
      pulse('1);
      msr(1'b0, 16'h0701, 64'h0);
      chk(rd, STATUS_VALID_MASK);
      $display("test status map done");
   endtask : t_map

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   // the tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock_in);
      bad_count++;
      test_done();
   end

   initial begin
      reset_n_in = 1'b0;
      en = 1'b1;
      req = '0;
      ovf = '0;
      sleep_m = 28'h001;
      bad_count = 0;
      check_count = 0;
      repeat (8) @(negedge clock_in);
      reset_n_in = 1'b1;
      t_reset();
      t_ctl();
      t_ovf();
      t_wake();
      t_en();
      t_map();
      test_done();
   end
endmodule : gpm_global_ctl_tb
